/* File: shared/margin_regs_pkg.sv */
// margin and gain register map: offsets, field positions, reset values, codes
// assumes a 32-bit classic wishbone bus with word-aligned registers
package margin_regs_pkg;
    localparam int REG_W = 16;
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 4;
    localparam int GAIN_MSB = 12;
    localparam int GAIN_LSB = 10;
    localparam int ADDR_W = 8;
    // printed register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CH2_MHIGH = 8'h01;
    localparam logic [7:0] IDX_CH2_MLOW = 8'h02;
    localparam logic [7:0] IDX_CH0_MLOW = 8'h0E;
    localparam logic [7:0] IDX_CH0_GAIN = 8'h0F;
    localparam logic [7:0] IDX_CH1_MLOW = 8'h14;
    localparam logic [15:0] RST_VAL = 16'h0000;
    localparam logic [15:0] CODE_MASK = 16'hFFF0;
    localparam logic [15:0] GAIN_MASK = 16'h1C00;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
    // reference and gain codes
    typedef enum logic [2:0] {
        GAIN_OFF = 3'h0,
        GAIN_1X_VDD = 3'h1,
        GAIN_1P5X_INT = 3'h2,
        GAIN_2X_INT = 3'h3,
        GAIN_3X_INT = 3'h4,
        GAIN_4X_INT = 3'h5
    } gain_code_t;
endpackage : margin_regs_pkg

/* File: rtl/masked_reg.sv */
// one 16-bit read/write register whose unused bits are held at zero
// assumes write strobe and data come from the bus slave on the same clock
`timescale 1ns/1ps
module masked_reg
    import margin_regs_pkg::*;
#(
    parameter logic [15:0] MASK = CODE_MASK
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] we_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] q_o
);
    logic [15:0] val_ff;
    logic [15:0] nxt_val;
    logic [15:0] lane;

    // per byte lane update; ignored bits never store
    assign lane = {{8{we_i[1]}}, {8{we_i[0]}}};
    assign nxt_val = ((wdata_i & lane) | (val_ff & ~lane)) & MASK;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            val_ff <= RST_VAL;
        end else begin
            val_ff <= nxt_val;
        end
    end

    assign q_o = val_ff;
endmodule : masked_reg

/* File: rtl/gain_decode.sv */
// decodes the channel 0 reference and gain field
// assumes field comes straight from the register
`timescale 1ns/1ps
module gain_decode
    import margin_regs_pkg::*;
(
    input wire logic [2:0] code_i,
    output logic vdd_ref_o,
    output logic int_ref_o,
    output logic [2:0] gain_x2_o,
    output logic invalid_o
);
    // gain reported in half steps: 2=1x,3=1.5x,4=2x,6=3x,8=4x (8 wraps, so 3 bits hold /2)
    logic [3:0] half;
    always_comb begin
        half = 4'h0;
        vdd_ref_o = 1'b0;
        int_ref_o = 1'b0;
        invalid_o = 1'b0;
        case (gain_code_t'(code_i))
            GAIN_1X_VDD: begin
                vdd_ref_o = 1'b1;
                half = 4'h2;
            end
            GAIN_1P5X_INT: begin
                int_ref_o = 1'b1;
                half = 4'h3;
            end
            GAIN_2X_INT: begin
                int_ref_o = 1'b1;
                half = 4'h4;
            end
            GAIN_3X_INT: begin
                int_ref_o = 1'b1;
                half = 4'h6;
            end
            GAIN_4X_INT: begin
                int_ref_o = 1'b1;
                half = 4'h8;
            end
            default: begin
                invalid_o = 1'b1;
            end
        endcase
    end
    assign gain_x2_o = half[3:1];
endmodule : gain_decode

/* File: rtl/dac_margin_gain_regs.sv */
// margin code and channel 0 gain registers behind a classic wishbone slave
// assumes a synchronous reset and a single-cycle classic master
//
// Contract
// - channel 2 margin-high code held in bits 15..4, read and write
// - channel 0 margin-low code register at index 0Eh, bits 15..4
// - channel 1 margin-low code register at index 14h, bits 15..4
// - channel 2 margin-low code register at index 02h, bits 15..4
// - codes are unsigned straight binary, msb at bit 15
// - bits 3..0 and ignored positions are dropped and reset to zero
// - gain code 001 selects unity gain with supply reference
// - codes 010..101 select internal reference, 1.5, 2, 3, 4 gain
// - every register resets to all zeros
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
module dac_margin_gain_regs
    import margin_regs_pkg::*;
#(
    parameter int CODE_BITS = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W+1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic [CODE_BITS-1:0] ch2_high_code_o,
    output logic [CODE_BITS-1:0] ch2_low_code_o,
    output logic [CODE_BITS-1:0] ch0_low_code_o,
    output logic [CODE_BITS-1:0] ch1_low_code_o,
    output logic ch0_vdd_ref_o,
    output logic ch0_int_ref_o,
    output logic [2:0] ch0_gain_x2_o,
    output logic ch0_gain_invalid_o
);
    localparam int NREG = 5;
    // top code bits kept; rest of field is ignored per variant
    localparam logic [15:0] VAR_MASK =
        CODE_MASK & ~((16'h0001 << (CODE_LSB + 12 - CODE_BITS)) - 16'h0001);
    localparam logic [15:0] MASKS [NREG] =
        '{VAR_MASK, VAR_MASK, VAR_MASK, GAIN_MASK, VAR_MASK};
    localparam logic [7:0] IDXS [NREG] =
        '{IDX_CH2_MHIGH, IDX_CH2_MLOW, IDX_CH0_MLOW, IDX_CH0_GAIN, IDX_CH1_MLOW};

    logic ack_ff;
    logic [31:0] rd_ff;
    logic [31:0] nxt_rd;
    logic [7:0] idx;
    logic req;
    logic wr_take;
    logic [NREG-1:0] hit;
    logic [15:0] q [NREG];
    logic [2:0] gain_field;

    // bus decode; an access is answered one cycle after it appears
    assign idx = adr_i[ADDR_W+1:2];
    assign req = cyc_i & stb_i & ~ack_ff;
    assign wr_take = req & we_i;

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_reg
            logic [1:0] lane_we;
            assign hit[g] = (idx == IDXS[g]);
            assign lane_we = {2{wr_take & hit[g]}} & sel_i[1:0];
            masked_reg #(.MASK(MASKS[g])) u_reg (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .we_i(lane_we),
                .wdata_i(dat_i[15:0]),
                .q_o(q[g])
            );
        end
    endgenerate

    // read mux; unmapped reads zero and still ack
    always_comb begin
        nxt_rd = UNMAPPED_RD;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                nxt_rd = {16'h0000, q[i]};
            end
        end
    end

    // ack and read data registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rd_ff <= UNMAPPED_RD;
        end else begin
            ack_ff <= req;
            if (req && !we_i) begin
                rd_ff <= nxt_rd;
            end
        end
    end
    assign ack_o = ack_ff;
    assign dat_o = rd_ff;

    // left-justified straight-binary codes out to the converters
    assign ch2_high_code_o = q[0][CODE_MSB -: CODE_BITS];
    assign ch2_low_code_o = q[1][CODE_MSB -: CODE_BITS];
    assign ch0_low_code_o = q[2][CODE_MSB -: CODE_BITS];
    assign ch1_low_code_o = q[4][CODE_MSB -: CODE_BITS];
    assign gain_field = q[3][GAIN_MSB:GAIN_LSB];

    // reference and gain selection for channel 0
    gain_decode u_gain (
        .code_i(gain_field),
        .vdd_ref_o(ch0_vdd_ref_o),
        .int_ref_o(ch0_int_ref_o),
        .gain_x2_o(ch0_gain_x2_o),
        .invalid_o(ch0_gain_invalid_o)
    );

    // checks
    a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> ack_o) else $error("no ack after request");
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack held too long");
    a_ch2_high_wr: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && idx == IDX_CH2_MHIGH && sel_i[1:0] == 2'b11
        |=> q[0] == ($past(dat_i[15:0]) & VAR_MASK)) else $error("ch2 high not stored");
    a_ch0_low_wr: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && idx == IDX_CH0_MLOW && sel_i[1:0] == 2'b11
        |=> ch0_low_code_o == $past(dat_i[15:16-CODE_BITS])) else $error("ch0 low wrong");
    a_ch1_low_wr: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && idx == IDX_CH1_MLOW && sel_i[1:0] == 2'b11
        |=> ch1_low_code_o == $past(dat_i[15:16-CODE_BITS])) else $error("ch1 low wrong");
    a_ch2_low_wr: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && idx == IDX_CH2_MLOW && sel_i[1:0] == 2'b11
        |=> ch2_low_code_o == $past(dat_i[15:16-CODE_BITS])) else $error("ch2 low wrong");
    a_low_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && !$past(we_i) |-> dat_o[3:0] == 4'h0 && dat_o[31:16] == 16'h0000)
        else $error("ignored bits read nonzero");
    a_gain_unity: assert property (@(posedge clk_i) disable iff (rst_i)
        gain_field == 3'b001 |-> ch0_vdd_ref_o && ch0_gain_x2_o == 3'h1)
        else $error("unity gain not selected");
    a_gain_internal: assert property (@(posedge clk_i) disable iff (rst_i)
        gain_field inside {[3'b010:3'b101]} |-> ch0_int_ref_o && !ch0_gain_invalid_o)
        else $error("internal reference not selected");
    a_reset_zero: assert property (@(posedge clk_i)
        !rst_i && $past(rst_i)
        |-> q[0] == RST_VAL && q[1] == RST_VAL && q[2] == RST_VAL
            && q[3] == RST_VAL && q[4] == RST_VAL)
        else $error("reset not zero");
    a_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && hit[2] |=> dat_o == {16'h0000, $past(q[2])})
        else $error("read back mismatch");

    // helper terms shared by the checks below
    logic rd_take;
    logic any_hit;
    assign rd_take = req & ~we_i;
    assign any_hit = |hit;

    // ack answers only a taken request, and only one cycle later
    a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
        !req
        |=> !ack_o)
        else $error("ack without a request");
    a_ack_rose_req: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ack_o)
        |-> $past(cyc_i && stb_i))
        else $error("ack rose without strobe");

    // read data stands until the next read is taken
    a_rdata_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        !rd_take
        |=> $stable(dat_o))
        else $error("read data moved without a read");

    // every mapped register reads back its stored value in the low half
    a_read_ch2_high: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && hit[0]
        |=> dat_o == {16'h0000, $past(q[0])})
        else $error("ch2 high read back wrong");
    a_read_ch2_low: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && hit[1]
        |=> dat_o == {16'h0000, $past(q[1])})
        else $error("ch2 low read back wrong");
    a_read_ch0_gain: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && hit[3]
        |=> dat_o == {16'h0000, $past(q[3])})
        else $error("ch0 gain read back wrong");
    a_read_ch1_low: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && hit[4]
        |=> dat_o == {16'h0000, $past(q[4])})
        else $error("ch1 low read back wrong");

    // each write lands in its own register, masked to the kept bits
    a_ch2_low_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit[1] && sel_i[1:0] == 2'b11
        |=> q[1] == ($past(dat_i[15:0]) & VAR_MASK))
        else $error("ch2 low not stored");
    a_ch0_low_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit[2] && sel_i[1:0] == 2'b11
        |=> q[2] == ($past(dat_i[15:0]) & VAR_MASK))
        else $error("ch0 low not stored");
    a_ch1_low_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit[4] && sel_i[1:0] == 2'b11
        |=> q[4] == ($past(dat_i[15:0]) & VAR_MASK))
        else $error("ch1 low not stored");
    a_gain_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit[3] && sel_i[1:0] == 2'b11
        |=> q[3] == ($past(dat_i[15:0]) & GAIN_MASK))
        else $error("ch0 gain not stored");
    a_ch2_high_code: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit[0] && sel_i[1:0] == 2'b11
        |=> ch2_high_code_o == $past(dat_i[15:16-CODE_BITS]))
        else $error("ch2 high code not left-justified");

    // a write to one register leaves the other four alone
    a_wr0_isolated: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit[0]
        |=> $stable(q[1]) && $stable(q[2])
            && $stable(q[3]) && $stable(q[4]))
        else $error("ch2 high write leaked");
    a_wr1_isolated: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit[1]
        |=> $stable(q[0]) && $stable(q[2])
            && $stable(q[3]) && $stable(q[4]))
        else $error("ch2 low write leaked");
    a_wr2_isolated: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit[2]
        |=> $stable(q[0]) && $stable(q[1])
            && $stable(q[3]) && $stable(q[4]))
        else $error("ch0 low write leaked");
    a_wr3_isolated: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit[3]
        |=> $stable(q[0]) && $stable(q[1])
            && $stable(q[2]) && $stable(q[4]))
        else $error("ch0 gain write leaked");
    a_wr4_isolated: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit[4]
        |=> $stable(q[0]) && $stable(q[1])
            && $stable(q[2]) && $stable(q[3]))
        else $error("ch1 low write leaked");

    // unmapped places read zero and are never stored; reads store nothing
    a_unmapped_rd: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && !any_hit
        |=> dat_o == UNMAPPED_RD)
        else $error("unmapped read not zero");
    a_unmapped_wr: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && !any_hit
        |=> $stable(q[0]) && $stable(q[1]) && $stable(q[2])
            && $stable(q[3]) && $stable(q[4]))
        else $error("unmapped write changed a register");
    a_read_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take
        |=> $stable(q[0]) && $stable(q[1]) && $stable(q[2])
            && $stable(q[3]) && $stable(q[4]))
        else $error("read changed a register");

    // ignored positions never hold a one, whatever the host wrote
    a_ign_margin: assert property (@(posedge clk_i) disable iff (rst_i)
        ((q[0] | q[1] | q[2] | q[4]) & ~VAR_MASK) == 16'h0000)
        else $error("ignored margin bits stored");
    a_ign_gain: assert property (@(posedge clk_i) disable iff (rst_i)
        (q[3] & ~GAIN_MASK) == 16'h0000)
        else $error("ignored gain bits stored");

    // outputs leave reset idle: no ack, zero data and codes, gain flagged
    a_reset_outputs: assert property (@(posedge clk_i)
        !rst_i && $past(rst_i)
        |-> ack_o == 1'b0 && dat_o == UNMAPPED_RD && ch0_gain_invalid_o
            && ch2_high_code_o == '0 && ch2_low_code_o == '0
            && ch0_low_code_o == '0 && ch1_low_code_o == '0)
        else $error("outputs not at reset values");

    // each gain code picks its reference and gain; other codes are flagged
    a_gain_1p5x: assert property (@(posedge clk_i) disable iff (rst_i)
        gain_field == 3'b010
        |-> ch0_int_ref_o && !ch0_vdd_ref_o && ch0_gain_x2_o == 3'h1)
        else $error("gain 1.5 not selected");
    a_gain_2x: assert property (@(posedge clk_i) disable iff (rst_i)
        gain_field == 3'b011
        |-> ch0_int_ref_o && !ch0_vdd_ref_o && ch0_gain_x2_o == 3'h2)
        else $error("gain 2 not selected");
    a_gain_3x: assert property (@(posedge clk_i) disable iff (rst_i)
        gain_field == 3'b100
        |-> ch0_int_ref_o && !ch0_vdd_ref_o && ch0_gain_x2_o == 3'h3)
        else $error("gain 3 not selected");
    a_gain_4x: assert property (@(posedge clk_i) disable iff (rst_i)
        gain_field == 3'b101
        |-> ch0_int_ref_o && !ch0_vdd_ref_o && ch0_gain_x2_o == 3'h4)
        else $error("gain 4 not selected");
    a_gain_invalid: assert property (@(posedge clk_i) disable iff (rst_i)
        !(gain_field inside {[3'b001:3'b101]})
        |-> ch0_gain_invalid_o && !ch0_vdd_ref_o && !ch0_int_ref_o
            && ch0_gain_x2_o == 3'h0)
        else $error("invalid gain code not flagged");
    a_vdd_only_unity: assert property (@(posedge clk_i) disable iff (rst_i)
        ch0_vdd_ref_o
        |-> gain_field == 3'b001)
        else $error("supply reference on a wrong code");

    c_write: cover property (@(posedge clk_i) wr_take && hit[0]);
    c_read: cover property (@(posedge clk_i) req && !we_i && hit[3]);
    c_unmapped: cover property (@(posedge clk_i) req && hit == '0);
    c_gain_invalid: cover property (@(posedge clk_i) ack_o && ch0_gain_invalid_o);
    c_internal_ref: cover property (@(posedge clk_i) ack_o && ch0_int_ref_o);
endmodule : dac_margin_gain_regs

/* File: dv/wb_host_model.sv */
// classic wishbone host model that programs the margin and gain registers
// assumes the bench calls xfer after a clock edge and bounds the wait itself
`timescale 1ns/1ps
module wb_host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [9:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    // idle bus at time zero
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // one word per call, several cycles each; gain codes come from the bench
    task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o} <= {2'b11, w, a, 4'h3};
        dat_o <= {16'h0000, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        {cyc_o, stb_o} <= 2'b00;
        adr_o <= ~a; // released lines do not keep the last value
        dat_o <= ~dat_o;
        @(posedge clk_i);
    endtask : xfer
endmodule : wb_host_model

/* File: dv/dac_margin_gain_regs_tb_top.sv */
// self-checking bench for the margin and gain register bank
// runs the 10-bit and 8-bit builds on one bus; acknowledge is one cycle late
`timescale 1ns/1ps
module dac_margin_gain_regs_tb_top
    import margin_regs_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, vdd, intr, inval;
    logic [9:0] adr, c2h, c2l, c0l, c1l;
    logic [3:0] sel;
    logic [31:0] wd, rd, q;
    logic [2:0] gx2;
    logic [7:0] h8, l2, l0, l1;
    logic [31:0] rd8;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    wire logic [49:0] codes = {c1l, 10'h000, c0l, c2l, c2h};
    wire logic [39:0] codes8 = {l1, 8'h00, l0, l2, h8};
    localparam logic [7:0] IDX [5] = '{IDX_CH2_MHIGH, IDX_CH2_MLOW, IDX_CH0_MLOW,
                                       IDX_CH0_GAIN, IDX_CH1_MLOW};
    localparam logic [2:0] GX [8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0};
    // 250 MHz clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    wb_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
    dac_margin_gain_regs #(.CODE_BITS(10)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd),
        .ack_o(ack), .ch2_high_code_o(c2h), .ch2_low_code_o(c2l), .ch0_low_code_o(c0l),
        .ch1_low_code_o(c1l), .ch0_vdd_ref_o(vdd), .ch0_int_ref_o(intr),
        .ch0_gain_x2_o(gx2), .ch0_gain_invalid_o(inval));
    // 8-bit build listens to the same bus; its ack matches the first one
    dac_margin_gain_regs #(.CODE_BITS(8)) DUT8 (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd8),
        .ack_o(), .ch2_high_code_o(h8), .ch2_low_code_o(l2), .ch0_low_code_o(l0),
        .ch1_low_code_o(l1), .ch0_vdd_ref_o(), .ch0_int_ref_o(),
        .ch0_gain_x2_o(), .ch0_gain_invalid_o());
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 3000) begin
            miscompares++;
            stop_test();
        end
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            host.xfer(1'b0, {IDX[i], 2'b00}, 16'h0000, q);
            check(q, 32'h0000_0000);
            check(rd8, 32'h0000_0000);
        end
        check(32'(inval), 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            if (i != 3) begin
                host.xfer(1'b1, {IDX[i], 2'b00}, 16'hFFFF, q);
                host.xfer(1'b0, {IDX[i], 2'b00}, 16'h0000, q);
                check(q, 32'h0000_FFC0);
                check(rd8, 32'h0000_FF00);
                host.xfer(1'b1, {IDX[i], 2'b00}, 16'hA5A5, q);
                host.xfer(1'b0, {IDX[i], 2'b00}, 16'h0000, q);
                check(q, 32'h0000_A580);
                check(rd8, 32'h0000_A500);
                check(32'(codes[i*10 +: 10]), 32'h0000_0296);
                check(32'(codes8[i*8 +: 8]), 32'h0000_00A5);
            end
        end
        // the host programs only the five valid gain codes, ignored bits all set
        for (int j = 1; j < 6; j++) begin
            host.xfer(1'b1, {IDX_CH0_GAIN, 2'b00}, {3'b111, 3'(j), 10'h3FF}, q);
            host.xfer(1'b0, {IDX_CH0_GAIN, 2'b00}, 16'h0000, q);
            check(q, {16'h0000, 3'b000, 3'(j), 10'h000});
            check(rd8, {16'h0000, 3'b000, 3'(j), 10'h000});
            check(32'(vdd), 32'(j == 1));
            check(32'(intr), 32'(j >= 2 && j <= 5));
            check(32'(inval), 32'(j == 0 || j > 5));
            check(32'(gx2), 32'(GX[j]));
        end
        // unmapped place: dropped write, zero read
        host.xfer(1'b1, 10'h00C, 16'hFFFF, q);
        host.xfer(1'b0, 10'h00C, 16'h0000, q);
        check(q, 32'h0000_0000);
        check(rd8, 32'h0000_0000);
        host.xfer(1'b0, {IDX_CH2_MHIGH, 2'b00}, 16'h0000, q);
        check(q, 32'h0000_A580);
        check(rd8, 32'h0000_A500);
        stop_test();
    end
endmodule : dac_margin_gain_regs_tb_top
